// [verilog/frc_pkg.sv]
// constants, register map and carrier types for the free running 16-bit counter
package frc_pkg;
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam logic [7:0] OFS_COUNT_HIGH = 8'h00;
	localparam logic [7:0] OFS_COUNT_LOW = 8'h04;
	localparam logic [7:0] OFS_SHADOW_HIGH = 8'h08;
	localparam logic [7:0] OFS_SHADOW_LOW = 8'h0C;
	localparam logic [7:0] OFS_FLAGS = 8'h10;
	localparam logic [7:0] OFS_CTRL_ONE = 8'h14;
	localparam logic [7:0] OFS_CTRL_TWO = 8'h18;
	localparam logic [7:0] OFS_EVT_STATUS = 8'h1C;
	localparam logic [7:0] OFS_EVT_MASK = 8'h20;
	localparam int unsigned BIT_WRAP_FLAG = 0;
	localparam int unsigned BIT_WRAP_IRQ_EN = 0;
	localparam int unsigned BIT_DIV_SEL_LO = 0;
	localparam int unsigned BIT_EXT_EDGE = 2;
	localparam int unsigned BIT_EVT_WRAP = 0;
	localparam int unsigned BIT_EVT_EXT = 1;
	localparam logic [15:0] COUNT_RESET = 16'hFFFC;
	localparam logic [15:0] COUNT_TOP = 16'hFFFF;
	localparam logic [2:0] PRESC_RESET = 3'h0;
	localparam logic [1:0] DIV_BY_2 = 2'h0;
	localparam logic [1:0] DIV_BY_4 = 2'h1;
	localparam logic [1:0] DIV_BY_8 = 2'h2;
	localparam logic [1:0] DIV_EXT = 2'h3;
	localparam int unsigned EXT_MIN_GAP = 4;

	typedef enum logic {
		FRC_RD_LIVE = 1'b0,
		FRC_RD_HELD = 1'b1
	} frc_rd_e;

	typedef struct packed {
		logic ext_edge_select;
		logic [1:0] tick_divider_select;
	} frc_ctrl_s;

	typedef struct packed {
		logic ext_evt;
		logic wrap_evt;
	} frc_evt_s;
endpackage

// [verilog/frc_counter.sv]
// free running 16-bit counter with prescaler, buffered byte reads and wrap interrupt
// What this block does
// - 16-bit up-counter advanced by a prescaler
// - tick is clk/2, /4, /8 or external
// - divider select both ones picks external clock
// - reset and low-byte writes load FFFC
// - both ports same count; shadow low keeps flag
// - high read buffers low byte until low read
// - lone low read gives live low byte
// - wrap FFFF to 0000 sets wrap flag
// - irq when flag, enable, cpu mask clear
// - flag clears after status read, then low access
// - counter keeps counting in wait mode
// - halt freezes count; resumes or resets after
// - edge select picks rising or falling external edge
// - all counter updates on the cpu clock
// - unbonded timer input reads as one
//
// Chosen here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
module frc_counter #(
	parameter logic EXT_PIN_BONDED = 1'b1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ext_tick_pin,
	input wire logic cpu_irq_mask,
	input wire logic halt_mode,
	output logic irq
);
	import frc_pkg::*;

	logic [15:0] count_q, count_d;
	logic [2:0] presc_q, presc_d;
	logic ext_q, ext_d;
	logic wrap_flag_q, wrap_flag_d;
	logic clr_armed_q, clr_armed_d;
	frc_rd_e rd_q, rd_d;
	logic [7:0] low_buf_q, low_buf_d;
	logic wrap_irq_enable_q, wrap_irq_enable_d;
	frc_ctrl_s ctrl_q, ctrl_d;
	frc_evt_s evt_q, evt_d, mask_q, mask_d;
	logic [31:0] prdata_q, prdata_d;
	logic pslverr_q, pslverr_d;

	logic setup, access, rd_acc, wr_acc;
	logic hit_high, hit_low, hit_shadow_low, hit_any_low, hit_any_high;
	logic pin_level, ext_edge, tick, wrap;
	logic [7:0] low_now;

	function automatic logic [2:0] div_mask(input logic [1:0] sel);
		case (sel)
			DIV_BY_2: div_mask = 3'h1;
			DIV_BY_4: div_mask = 3'h3;
			default: div_mask = 3'h7;
		endcase
	endfunction

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == OFS_COUNT_HIGH) || (a == OFS_COUNT_LOW) || (a == OFS_SHADOW_HIGH) ||
			(a == OFS_SHADOW_LOW) || (a == OFS_FLAGS) || (a == OFS_CTRL_ONE) ||
			(a == OFS_CTRL_TWO) || (a == OFS_EVT_STATUS) || (a == OFS_EVT_MASK);
	endfunction

	// bus decode; answer comes in the first access cycle
	assign setup = psel && !penable;
	assign access = psel && penable;
	assign pready = access;
	assign rd_acc = access && !pwrite;
	assign wr_acc = access && pwrite;
	assign hit_high = paddr == OFS_COUNT_HIGH;
	assign hit_low = paddr == OFS_COUNT_LOW;
	assign hit_shadow_low = paddr == OFS_SHADOW_LOW;
	assign hit_any_low = hit_low || hit_shadow_low;
	assign hit_any_high = hit_high || (paddr == OFS_SHADOW_HIGH);
	assign prdata = prdata_q;
	assign pslverr = access && pslverr_q;

	// pin that is not bonded out reads high
	assign pin_level = EXT_PIN_BONDED ? ext_tick_pin : 1'b1;
	// edge select: one for rising, zero for falling
	assign ext_edge = ctrl_q.ext_edge_select ? (pin_level && !ext_q) : (!pin_level && ext_q);

	// internal ticks from the prescaler, external edge when both select bits set
	// halt freezes prescaler and counter; wait has no effect here
	// sampling an edge per clock relies on a slow external source
	always_comb begin
		if (halt_mode) begin
			tick = 1'b0;
		end else if (ctrl_q.tick_divider_select == DIV_EXT) begin
			tick = ext_edge;
		end else begin
			tick = (presc_q & div_mask(ctrl_q.tick_divider_select)) ==
				div_mask(ctrl_q.tick_divider_select);
		end
	end

	// wrap from the top value to zero
	assign wrap = tick && (count_q == COUNT_TOP);
	// both ports present the same count
	assign low_now = count_q[7:0];

	// counter and prescaler
	always_comb begin
		count_d = count_q;
		presc_d = presc_q;
		ext_d = pin_level;
		if (!halt_mode && ctrl_q.tick_divider_select != DIV_EXT) begin
			presc_d = presc_q + 3'h1;
		end
		if (tick) begin
			count_d = count_q + 16'h0001;
		end
		// any low-byte write restarts from the reload value
		if (wr_acc && hit_any_low) begin
			count_d = COUNT_RESET;
		end
	end

	// counter, prescaler and edge sampler all move on the one cpu clock
	always_ff @(posedge clk) begin
		if (rst) begin
			// reset value of both counter ports
			count_q <= COUNT_RESET;
			// prescaler restarts, first tick a full period later
			presc_q <= PRESC_RESET;
			// sampler starts at the pin level so no false edge follows reset
			ext_q <= pin_level;
		end else begin
			count_q <= count_d;
			presc_q <= presc_d;
			ext_q <= ext_d;
		end
	end

	// read buffer state
	always_comb begin
		rd_d = rd_q;
		low_buf_d = low_buf_q;
		// first high read buffers the low byte; later ones keep it
		// taken in setup with the high byte, so a carry before the access edge cannot split them
		if (setup && !pwrite && hit_any_high && rd_q == FRC_RD_LIVE) begin
			low_buf_d = low_now;
		end
		if (rd_acc && hit_any_high) begin
			rd_d = FRC_RD_HELD;
		end else if (rd_acc && hit_any_low) begin
			rd_d = FRC_RD_LIVE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rd_q <= FRC_RD_LIVE;
			low_buf_q <= 8'h00;
		end else begin
			rd_q <= rd_d;
			low_buf_q <= low_buf_d;
		end
	end

	// wrap flag with its two-step clear
	always_comb begin
		wrap_flag_d = wrap_flag_q;
		clr_armed_d = clr_armed_q;
		// step one: status read while the flag is set
		// arms only if the read really showed the flag to software
		if (rd_acc && paddr == OFS_FLAGS && prdata_q[BIT_WRAP_FLAG]) begin
			clr_armed_d = 1'b1;
		end
		// step two: any access to the main low byte; shadow low not counted
		if (access && hit_low && clr_armed_q) begin
			wrap_flag_d = 1'b0;
			clr_armed_d = 1'b0;
		end
		// a wrap in the clearing cycle still sets the flag
		if (wrap) begin
			wrap_flag_d = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wrap_flag_q <= 1'b0;
			clr_armed_q <= 1'b0;
		end else begin
			wrap_flag_q <= wrap_flag_d;
			clr_armed_q <= clr_armed_d;
		end
	end

	// software registers and event status
	always_comb begin
		wrap_irq_enable_d = wrap_irq_enable_q;
		ctrl_d = ctrl_q;
		mask_d = mask_q;
		evt_d = evt_q;
		if (wr_acc && paddr == OFS_CTRL_ONE) begin
			wrap_irq_enable_d = pwdata[BIT_WRAP_IRQ_EN];
		end
		if (wr_acc && paddr == OFS_CTRL_TWO) begin
			ctrl_d.tick_divider_select = pwdata[BIT_DIV_SEL_LO +: 2];
			ctrl_d.ext_edge_select = pwdata[BIT_EXT_EDGE];
		end
		if (wr_acc && paddr == OFS_EVT_MASK) begin
			mask_d = pwdata[1:0];
		end
		// write one to clear; a new event in the same cycle wins
		if (wr_acc && paddr == OFS_EVT_STATUS) begin
			evt_d = evt_q & ~frc_evt_s'(pwdata[1:0]);
		end
		if (wrap) begin
			evt_d.wrap_evt = 1'b1;
		end
		if (tick && ctrl_q.tick_divider_select == DIV_EXT) begin
			evt_d.ext_evt = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wrap_irq_enable_q <= 1'b0;
			ctrl_q <= '0;
			mask_q <= '0;
			evt_q <= '0;
		end else begin
			wrap_irq_enable_q <= wrap_irq_enable_d;
			ctrl_q <= ctrl_d;
			mask_q <= mask_d;
			evt_q <= evt_d;
		end
	end

	// wrap request held until enable set and cpu mask clear
	assign irq = (wrap_flag_q && wrap_irq_enable_q && !cpu_irq_mask) || ((evt_q & mask_q) != '0);

	// read data captured in setup; buffer state cannot move before the access edge, but a wrap can still set the flag
	always_comb begin
		prdata_d = prdata_q;
		pslverr_d = pslverr_q;
		if (setup) begin
			prdata_d = 32'h0000_0000;
			pslverr_d = !mapped(paddr);
			case (paddr)
				OFS_COUNT_HIGH, OFS_SHADOW_HIGH: begin
					prdata_d[7:0] = count_q[15:8];
				end
				// live low byte unless a buffered sequence is open
				OFS_COUNT_LOW, OFS_SHADOW_LOW: begin
					prdata_d[7:0] = (rd_q == FRC_RD_HELD) ? low_buf_q : low_now;
				end
				OFS_FLAGS: begin
					prdata_d[BIT_WRAP_FLAG] = wrap_flag_q;
				end
				OFS_CTRL_ONE: begin
					prdata_d[BIT_WRAP_IRQ_EN] = wrap_irq_enable_q;
				end
				OFS_CTRL_TWO: begin
					prdata_d[BIT_DIV_SEL_LO +: 2] = ctrl_q.tick_divider_select;
					prdata_d[BIT_EXT_EDGE] = ctrl_q.ext_edge_select;
				end
				OFS_EVT_STATUS: begin
					prdata_d[1:0] = evt_q;
				end
				OFS_EVT_MASK: begin
					prdata_d[1:0] = mask_q;
				end
				default: begin
					prdata_d = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// one tick advances the count by exactly one
	a_count_step: assert property (tick && !(wr_acc && hit_any_low) |=> count_q == $past(count_q) + 16'h0001)
		else $error("count did not advance by one on a tick");
	a_halt_freeze: assert property (halt_mode && !(wr_acc && hit_any_low) |=> $stable(count_q))
		else $error("count moved during halt");
	// low byte write loads the reload value
	a_low_reload: assert property (wr_acc && hit_any_low |=> count_q == COUNT_RESET)
		else $error("low byte write did not reload counter");
	// wrap sets the flag next cycle
	a_wrap_sets: assert property (wrap && !(wr_acc && hit_any_low) |=> wrap_flag_q && count_q == 16'h0000)
		else $error("wrap did not set the flag");
	// flag only falls after arming and a main low access
	a_flag_clear: assert property ($fell(wrap_flag_q) && !$past(rst)
		|-> $past(clr_armed_q) && $past(access && hit_low))
		else $error("wrap flag cleared without two-step sequence");
	// shadow low access never clears the flag
	a_shadow_keeps: assert property (access && hit_shadow_low && wrap_flag_q |=> wrap_flag_q)
		else $error("shadow low access cleared wrap flag");
	// buffer holds over repeated high reads
	a_buf_hold: assert property (rd_q == FRC_RD_HELD && rd_acc && hit_any_high |=> $stable(low_buf_q))
		else $error("low byte buffer changed during held sequence");
	// request follows flag, enable and cpu mask
	a_irq_wrap: assert property (wrap_flag_q && wrap_irq_enable_q && !cpu_irq_mask |-> irq)
		else $error("wrap irq missing");
	// divide by two ticks every second cycle
	a_div_two: assert property (ctrl_q.tick_divider_select == DIV_BY_2 && !halt_mode && tick
		##1 ctrl_q.tick_divider_select == DIV_BY_2 && !halt_mode
		##1 ctrl_q.tick_divider_select == DIV_BY_2 && !halt_mode |-> tick && !$past(tick))
		else $error("divide by two cadence wrong");
	// no tick in the first cycle after reset
	a_reset_presc: assert property ($fell(rst) |-> presc_q == PRESC_RESET)
		else $error("prescaler not cleared by reset");
	// lone low read returns the live byte
	a_live_low: assert property (setup && !pwrite && hit_any_low && rd_q == FRC_RD_LIVE
		|=> prdata_q[7:0] == $past(low_now))
		else $error("live low byte read wrong");
	// no selected edge, no external count
	a_ext_idle: assert property (ctrl_q.tick_divider_select == DIV_EXT && !ext_edge && !(wr_acc && hit_any_low)
		|=> $stable(count_q))
		else $error("count moved without a selected external edge");
	// count moves only on a tick or a reload
	a_count_only_tick: assert property (!tick && !(wr_acc && hit_any_low) |=> $stable(count_q))
		else $error("count moved without a tick");
	// high byte read returns the count high byte
	a_high_byte: assert property (setup && !pwrite && hit_any_high |=> prdata_q[7:0] == $past(count_q[15:8]))
		else $error("high byte read wrong");
	// low read inside a sequence returns the buffer
	a_held_low: assert property (setup && !pwrite && hit_any_low && rd_q == FRC_RD_HELD
		|=> prdata_q[7:0] == $past(low_buf_q))
		else $error("buffered low byte read wrong");
	// flag rises only on a wrap
	a_rise_wrap: assert property ($rose(wrap_flag_q) |-> $past(wrap))
		else $error("wrap flag set without a wrap");
	// wrap also marks the event status
	a_wrap_event: assert property (wrap |=> evt_q.wrap_evt)
		else $error("wrap event bit not set");
	// masked cpu and no event, no request
	a_irq_masked: assert property (cpu_irq_mask && (evt_q & mask_q) == 2'h0 |-> !irq)
		else $error("irq raised while cpu mask set");
	// status read showing the flag arms the clear
	a_arm_step: assert property (rd_acc && paddr == OFS_FLAGS && prdata_q[BIT_WRAP_FLAG] |=> clr_armed_q)
		else $error("status read did not arm the clear");
	// armed main low access clears the flag
	a_low_clears: assert property (access && hit_low && clr_armed_q && !wrap |=> !wrap_flag_q)
		else $error("armed low access left the flag set");
	a_halt_presc: assert property (halt_mode |=> $stable(presc_q))
		else $error("prescaler moved during halt");
	// counter leaves reset at the reload value
	a_reset_count: assert property ($fell(rst) |-> count_q == COUNT_RESET && !wrap_flag_q)
		else $error("counter not at reload value after reset");

	c_wrap: cover property (wrap);
	c_flag_cleared: cover property ($fell(wrap_flag_q));
	c_held_read: cover property (rd_q == FRC_RD_HELD ##[1:20] rd_q == FRC_RD_LIVE);
	c_ext_tick: cover property (tick && ctrl_q.tick_divider_select == DIV_EXT);
	c_div_eight: cover property (tick && ctrl_q.tick_divider_select == DIV_BY_8);
endmodule

// [dv/frc_ext_src.sv]
// external tick source driving the timer clock pin
`timescale 1ns/100ps
module frc_ext_src (
	input wire logic clk,
	input wire logic start,
	input wire logic [3:0] toggles,
	input wire logic [3:0] gap,
	output logic pin,
	output logic busy
);
	logic [3:0] left_q = 4'h0;
	logic [3:0] wait_q = 4'h0;
	logic pin_q = 1'b0;
	assign pin = pin_q;
	assign busy = left_q != 4'h0;
	always @(posedge clk) begin
		if (start && !busy) begin
			left_q <= toggles;
			wait_q <= (gap < 4'h4) ? 4'h4 : gap;
		end else if (busy) begin
			if (wait_q == 4'h0) begin
				pin_q <= ~pin_q;
				left_q <= left_q - 4'h1;
				wait_q <= (gap < 4'h4) ? 4'h4 : gap;
			end else begin
				wait_q <= wait_q - 4'h1;
			end
		end
	end
endmodule

// [dv/frc_counter_bench.sv]
// self-checking bench for the free running counter
`timescale 1ns/100ps
module frc_counter_bench;
	import frc_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic cpu_mask = 1'b0;
	logic halt = 1'b1;
	logic src_start = 1'b0;
	logic [3:0] src_toggles = 4'h0;
	logic [3:0] src_gap = 4'h4;
	logic [31:0] prdata;
	logic pready, pslverr, irq, ext_pin, src_busy, last_err;
	logic [31:0] lo_r = {24'h000000, COUNT_RESET[7:0]};
	logic [31:0] hi_r = {24'h000000, COUNT_RESET[15:8]};
	logic [31:0] exp_q[$];
	integer num_errors = 0;
	integer n_tests = 0;
	integer seed = 32'hB47B8EC3;
	integer k, t, e, n;

	frc_counter uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_tick_pin(ext_pin),
		.cpu_irq_mask(cpu_mask), .halt_mode(halt), .irq(irq));
	frc_ext_src src (.clk(clk), .start(src_start), .toggles(src_toggles), .gap(src_gap), .pin(ext_pin),
		.busy(src_busy));

	initial begin
		forever #(CLK_PERIOD_NS / 2) clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		n_tests++;
		if (seen !== want) begin
			num_errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, want);
		end
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// holds the request until pready is seen at a rising edge
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		exp_q.push_back(want);
		xfer(a, 1'b0, 32'h00000000);
	endtask

	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
			chk(prdata, exp_q.pop_front());
		end
	end

	initial begin
		#(CLK_PERIOD_NS * 20000);
		num_errors++;
		test_done();
	end

	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd(OFS_COUNT_LOW, lo_r);
		rd(OFS_COUNT_HIGH, hi_r);
		halt <= 1'b0;
		repeat (6) @(posedge clk);
		halt <= 1'b1;
		rd(OFS_SHADOW_HIGH, hi_r);
		rd(OFS_SHADOW_LOW, lo_r);
		rd(OFS_CTRL_TWO, 32'h00000000);
		rd(8'h24, 32'h00000000);
		chk({31'h0, last_err}, 32'h00000001);
		$display("test reset and buffered read done");
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		halt <= 1'b0;
		repeat (2) @(posedge clk);
		halt <= 1'b1;
		rd(OFS_COUNT_LOW, lo_r + 32'h1);
		$display("test prescaler after reset done");
		for (e = 1; e >= 0; e--) begin
			xfer(OFS_CTRL_TWO, 1'b1, {29'h0, e[0], DIV_EXT});
			xfer(OFS_COUNT_LOW, 1'b1, $random(seed));
			t = 2 + ($random(seed) & 3);
			k = ((e == 1) == (ext_pin == 1'b0)) ? (t + 1) / 2 : t / 2;
			halt <= 1'b0;
			src_toggles <= t[3:0];
			src_gap <= e[0] ? 4'h4 : 4'h9;
			src_start <= 1'b1;
			@(posedge clk);
			src_start <= 1'b0;
			@(posedge clk);
			while (src_busy) begin
				@(posedge clk);
			end
			repeat (4) @(posedge clk);
			halt <= 1'b1;
			rd(OFS_COUNT_LOW, lo_r + k);
		end
		rd(OFS_EVT_STATUS, 32'h00000002);
		xfer(OFS_EVT_STATUS, 1'b1, 32'h00000002);
		rd(OFS_EVT_STATUS, 32'h00000000);
		$display("test external clock done");
		xfer(OFS_CTRL_ONE, 1'b1, 32'h00000001);
		for (e = 0; e < 3; e++) begin
			xfer(OFS_CTRL_TWO, 1'b1, e);
			xfer(OFS_COUNT_LOW, 1'b1, $random(seed));
			halt <= 1'b0;
			k = 0;
			n = 2 << e;
			@(posedge clk);
			while (irq !== 1'b1 && k < 200) begin
				@(posedge clk);
				k++;
			end
			halt <= 1'b1;
			chk({31'h0, k >= 3 * n + 1 && k <= 4 * n}, 32'h00000001);
			cpu_mask <= 1'b1;
			@(posedge clk);
			chk({31'h0, irq}, 32'h00000000);
			cpu_mask <= 1'b0;
			@(posedge clk);
			chk({31'h0, irq}, 32'h00000001);
			rd(OFS_FLAGS, 32'h00000001);
			xfer(OFS_SHADOW_LOW, 1'b1, 32'h00000000);
			rd(OFS_FLAGS, 32'h00000001);
			xfer(OFS_COUNT_LOW, 1'b1, 32'h00000000);
			rd(OFS_FLAGS, 32'h00000000);
		end
		$display("test dividers and wrap flag done");
		xfer(OFS_CTRL_ONE, 1'b1, 32'h00000000);
		chk({31'h0, irq}, 32'h00000000);
		xfer(OFS_EVT_MASK, 1'b1, 32'h00000001);
		chk({31'h0, irq}, 32'h00000001);
		xfer(OFS_EVT_STATUS, 1'b1, 32'h00000001);
		chk({31'h0, irq}, 32'h00000000);
		rd(OFS_EVT_STATUS, 32'h00000000);
		chk(32'(exp_q.size()), 32'h00000000);
		$display("test event interrupt done");
		test_done();
	end
endmodule
